// >>> logic/ctm_pkg.sv
// constants and types shared by the compact timer design files
// assumes a single 100 MHz clock domain and an AXI4-Lite register port
`default_nettype none
package ctm_pkg;

  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'b00,
    CTM_MODE_UND = 2'b01,
    CTM_MODE_PWM = 2'b10,
    CTM_MODE_TMR = 2'b11
  } ctm_mode_e;

  // byte addresses of the register words
  localparam logic [7:0] CTM_OFF_CTRL0 = 8'h00;
  localparam logic [7:0] CTM_OFF_CTRL1 = 8'h04;
  localparam logic [7:0] CTM_OFF_CNTL = 8'h08;
  localparam logic [7:0] CTM_OFF_CNTH = 8'h0c;
  localparam logic [7:0] CTM_OFF_CMPL = 8'h10;
  localparam logic [7:0] CTM_OFF_CMPH = 8'h14;
  localparam logic [7:0] CTM_OFF_FLAG = 8'h18;

  // control zero fields
  localparam int CTM_C0_PAUSE = 7;
  localparam int CTM_C0_CKS_LO = 4;
  localparam int CTM_C0_ON = 3;
  // control one fields
  localparam int CTM_C1_MODE_LO = 6;
  localparam int CTM_C1_IO_LO = 4;
  localparam int CTM_C1_OC = 3;
  localparam int CTM_C1_POL = 2;
  localparam int CTM_C1_DPX = 1;
  localparam int CTM_C1_CCLR = 0;
  // flag register fields
  localparam int CTM_FL_A = 0;
  localparam int CTM_FL_P = 1;

  localparam logic [7:0] CTM_CTRL_RST = 8'h00;
  localparam logic [9:0] CTM_CNT_MAX = 10'h3ff;
  localparam logic [10:0] CTM_FULL_SPAN = 11'h400;
  localparam logic [1:0] CTM_RESP_OK = 2'b00;
  localparam logic [1:0] CTM_RESP_ERR = 2'b10;

  // period value to clock count: steps of 128, zero means 1024
  function automatic logic [10:0] ctm_scale128(input logic [2:0] p);
    ctm_scale128 = (p == 3'h0) ? CTM_FULL_SPAN : {1'b0, p, 7'h00};
  endfunction

endpackage
`default_nettype wire

// >>> logic/ctm_axil_slave.sv
// AXI4-Lite slave front end: turns bus transfers into register strobes
// assumes the parent decodes addresses and returns read data combinationally
`default_nettype none
module ctm_axil_slave import ctm_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic wr_en, // register write pulse
  output logic [ADDR_W-1:0] wr_addr, // held write address
  output logic [7:0] wr_data, // low byte of write data
  output logic wr_be0, // low byte lane enabled
  input wire logic wr_ok, // write address is mapped
  output logic [ADDR_W-1:0] rd_addr, // read address to decode
  output logic rd_en, // read taken this cycle
  input wire logic [7:0] rd_data, // decoded read byte
  input wire logic rd_ok // read address is mapped
);

  logic aw_full;
  logic w_full;

  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  // address and data may come in either order; fire once both are held
  assign wr_en = aw_full && w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_en = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_full <= 1'b0;
      wr_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end else if (wr_en) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_full <= 1'b0;
      wr_data <= 8'h00;
      wr_be0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      wr_data <= s_axi_wdata[7:0];
      wr_be0 <= s_axi_wstrb[0];
    end else if (wr_en) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CTM_RESP_OK;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? CTM_RESP_OK : CTM_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= CTM_RESP_OK;
    end else if (rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_ok ? rd_data : 8'h00};
      s_axi_rresp <= rd_ok ? CTM_RESP_OK : CTM_RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ctm_axil_slave
`default_nettype wire

// >>> logic/ctm_pin_out.sv
// output pin shaper: compare-match level, PWM waveform, polarity, enable
// assumes match and start events come from the counter on the same clock
`default_nettype none
module ctm_pin_out import ctm_pkg::*; (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset
  input wire ctm_mode_e mode, // operating mode
  input wire logic [1:0] io_fn, // output function bits
  input wire logic oc, // output level control
  input wire logic pol, // output invert
  input wire logic on_rise, // timer just switched on
  input wire logic a_set, // comparator A flag raised
  input wire logic pwm_active, // PWM waveform in active part
  output logic pin_out, // output pin level
  output logic pin_oe // output pin enable
);

  logic cmp_lvl;
  logic pwm_lvl;

  // only an A match moves the pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmp_lvl <= 1'b0;
    end else if (on_rise) begin
      cmp_lvl <= oc;
    end else if (mode == CTM_MODE_CMP && a_set) begin
      case (io_fn)
        2'b01: cmp_lvl <= 1'b0;
        2'b10: cmp_lvl <= 1'b1;
        2'b11: cmp_lvl <= !cmp_lvl;
        default: cmp_lvl <= cmp_lvl;
      endcase
    end
  end

  always_comb begin
    case (io_fn)
      2'b01: pwm_lvl = oc;
      2'b10: pwm_lvl = pwm_active ? oc : !oc;
      default: pwm_lvl = !oc;
    endcase
  end

  // pin left free in timer mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= ((mode == CTM_MODE_PWM) ? pwm_lvl : cmp_lvl) ^ pol;
      pin_oe <= (mode == CTM_MODE_CMP) || (mode == CTM_MODE_PWM);
    end
  end

  chk_init_level: assert property (@(posedge clk) disable iff (!rst_n)
    on_rise |=> cmp_lvl == $past(oc))
    else $error("pin not at initial level after start");
  chk_toggle_match: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == CTM_MODE_CMP && a_set && io_fn == 2'b11 && !on_rise)
    |=> cmp_lvl != $past(cmp_lvl))
    else $error("toggle on A match missing");
  chk_timer_free: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == CTM_MODE_TMR) |=> !pin_oe)
    else $error("pin driven in timer mode");
  chk_pwm_forced: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == CTM_MODE_PWM && io_fn == 2'b01)
    |=> pin_out == ($past(oc) ^ $past(pol)))
    else $error("forced active level wrong");

endmodule // ctm_pin_out
`default_nettype wire

// >>> logic/ctm_timer.sv
// compact 10-bit timer with compare output, timer and PWM modes
// assumes count_tick is a one-cycle enable from the clock-source selector
// on this clock; the selector is steered by the clk_sel output
//
// What this block does
// - count readable as low byte, high bits
// - comparator A in two read-write bytes
// - high byte bits 7..2 read zero
// - mode field picks compare, PWM, timer
// - clear-select low: P match clears, both flags
// - clear-select high: A clears, no P flag
// - A zero: overflow at 3FF, no flag
// - compare mode pin moves only on A
// - A match sets, clears or toggles pin
// - on-bit rise loads initial pin level
// - timer mode like compare, pin undriven
// - PWM ignores clear-select, swap picks roles
// - swap zero: period from P, duty A
// - swap one: period A, duty from P
// - duty at least period gives full duty
// - PWM flags on A and P matches
// - PWM level control sets active level
// - polarity bit inverts pin waveform
// - PWM counting continues while pin forced
// - each counter clear starts PWM period
// - compare functions: none, low, high, toggle
// - PWM functions: inactive, active, waveform
// - on rise zeroes count, off holds it
// - level bit: initial or active level
`default_nettype none
module ctm_timer import ctm_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic clk, // system clock, 100 MHz
  input wire logic rst_n, // synchronous reset
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic count_tick, // timer clock enable pulse
  output logic [2:0] clk_sel, // clock source select
  output logic timer_out, // output pin level
  output logic timer_out_en // output pin enable
);

  ////////////////////////////////////////////////////////////////////////
  // bus front end

  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_be0;
  logic wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic rd_en;
  logic [7:0] rd_data;
  logic rd_ok;

  ctm_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
    .clk(clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_be0(wr_be0),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    case (8'(a))
      CTM_OFF_CTRL0, CTM_OFF_CTRL1, CTM_OFF_CNTL, CTM_OFF_CNTH,
      CTM_OFF_CMPL, CTM_OFF_CMPH, CTM_OFF_FLAG: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  assign wr_ok = is_mapped(wr_addr) && (ADDR_W'(8'(wr_addr)) == wr_addr);
  assign rd_ok = is_mapped(rd_addr) && (ADDR_W'(8'(rd_addr)) == rd_addr);

  logic wr_go;
  assign wr_go = wr_en && wr_ok && wr_be0;

  ////////////////////////////////////////////////////////////////////////
  // software registers

  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [9:0] cmpa;
  logic [9:0] cnt;
  logic flag_a;
  logic flag_p;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl0 <= CTM_CTRL_RST;
    end else if (wr_go && 8'(wr_addr) == CTM_OFF_CTRL0) begin
      ctrl0 <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl1 <= CTM_CTRL_RST;
    end else if (wr_go && 8'(wr_addr) == CTM_OFF_CTRL1) begin
      ctrl1 <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmpa <= 10'h000;
    end else if (wr_go && 8'(wr_addr) == CTM_OFF_CMPL) begin
      cmpa[7:0] <= wr_data;
    end else if (wr_go && 8'(wr_addr) == CTM_OFF_CMPH) begin
      cmpa[9:8] <= wr_data[1:0];
    end
  end

  logic tm_on;
  logic pause;
  logic [2:0] rp;
  ctm_mode_e mode;
  logic [1:0] io_fn;
  logic oc;
  logic pol;
  logic dpx;
  logic cclr;

  assign pause = ctrl0[CTM_C0_PAUSE];
  assign clk_sel = ctrl0[CTM_C0_CKS_LO +: 3];
  assign tm_on = ctrl0[CTM_C0_ON];
  assign rp = ctrl0[2:0];
  assign mode = ctm_mode_e'(ctrl1[CTM_C1_MODE_LO +: 2]);
  assign io_fn = ctrl1[CTM_C1_IO_LO +: 2];
  assign oc = ctrl1[CTM_C1_OC];
  assign pol = ctrl1[CTM_C1_POL];
  assign dpx = ctrl1[CTM_C1_DPX];
  assign cclr = ctrl1[CTM_C1_CCLR];

  // read mux, unused high bits zero
  always_comb begin
    case (8'(rd_addr))
      CTM_OFF_CTRL0: rd_data = ctrl0;
      CTM_OFF_CTRL1: rd_data = ctrl1;
      CTM_OFF_CNTL: rd_data = cnt[7:0];
      CTM_OFF_CNTH: rd_data = {6'h00, cnt[9:8]};
      CTM_OFF_CMPL: rd_data = cmpa[7:0];
      CTM_OFF_CMPH: rd_data = {6'h00, cmpa[9:8]};
      CTM_OFF_FLAG: rd_data = {6'h00, flag_p, flag_a};
      default: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // counter and comparators

  logic on_prev;
  logic on_rise;
  logic cnt_step;
  logic [9:0] cnt_inc;
  logic a_hit;
  logic p_hit;
  logic is_pwm;
  logic cnt_clr;
  logic a_set;
  logic p_set;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      on_prev <= 1'b0;
    end else begin
      on_prev <= tm_on;
    end
  end

  assign on_rise = tm_on && !on_prev;
  // the start cycle itself never counts, so a restart always reads zero
  // stepping never looks at the output function
  assign cnt_step = tm_on && !on_rise && !pause && count_tick;
  assign cnt_inc = cnt + 10'h001;
  assign is_pwm = (mode == CTM_MODE_PWM);

  // match on the value being entered
  // an all-zero A never matches, the count just wraps
  assign a_hit = (cnt_inc == cmpa) && (cmpa != 10'h000);
  assign p_hit = (rp == 3'h0) ? (cnt == CTM_CNT_MAX)
               : (cnt_inc[9:7] == rp && cnt_inc[6:0] == 7'h00);

  // clear source by mode, then swap bit (PWM) or clear-select (other modes)
  assign cnt_clr = is_pwm ? (dpx ? a_hit : p_hit)
                          : (cclr ? a_hit : p_hit);

  // start zeroes, off holds residual count
  // a clear starts the next period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 10'h000;
    end else if (on_rise) begin
      cnt <= 10'h000;
    end else if (cnt_step) begin
      cnt <= cnt_clr ? 10'h000 : cnt_inc;
    end
  end

  // no P flag with clear-select high, except in PWM mode
  assign a_set = cnt_step && a_hit;
  assign p_set = cnt_step && p_hit && (is_pwm || !cclr);

  logic clr_a;
  logic clr_p;
  assign clr_a = wr_go && 8'(wr_addr) == CTM_OFF_FLAG && wr_data[CTM_FL_A];
  assign clr_p = wr_go && 8'(wr_addr) == CTM_OFF_FLAG && wr_data[CTM_FL_P];

  // write one to clear; a match in the same cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_a <= 1'b0;
    end else if (a_set) begin
      flag_a <= 1'b1;
    end else if (clr_a) begin
      flag_a <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_p <= 1'b0;
    end else if (p_set) begin
      flag_p <= 1'b1;
    end else if (clr_p) begin
      flag_p <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PWM period and duty

  logic [10:0] period_len;
  logic [10:0] duty_len;
  logic pwm_active;

  // period and duty by swap bit
  assign period_len = dpx ? ((cmpa == 10'h000) ? CTM_FULL_SPAN
                                               : {1'b0, cmpa})
                          : ctm_scale128(rp);
  assign duty_len = dpx ? ctm_scale128(rp) : {1'b0, cmpa};
  // duty not below period stays active
  assign pwm_active = ({1'b0, cnt} < duty_len) || (duty_len >= period_len);

  ////////////////////////////////////////////////////////////////////////
  // output pin

  ctm_pin_out u_pin (
    .clk(clk),
    .rst_n(rst_n),
    .mode(mode),
    .io_fn(io_fn),
    .oc(oc),
    .pol(pol),
    .on_rise(on_rise),
    .a_set(a_set),
    .pwm_active(pwm_active),
    .pin_out(timer_out),
    .pin_oe(timer_out_en)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks

  chk_start_zero: assert property (@(posedge clk) disable iff (!rst_n)
    on_rise |=> cnt == 10'h000)
    else $error("count not zero after start");
  chk_off_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (!tm_on && $past(!tm_on)) |=> $stable(cnt))
    else $error("count moved while off");
  chk_p_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_step && !is_pwm && !cclr && p_hit)
    |=> cnt == 10'h000 && flag_p)
    else $error("P match did not clear and flag");
  chk_a_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_step && !is_pwm && cclr && a_hit)
    |=> cnt == 10'h000 && flag_a)
    else $error("A match did not clear and flag");
  chk_no_p_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (!is_pwm && cclr && !flag_p) |=> !flag_p)
    else $error("P flag raised with clear-select high");
  chk_wrap_noflag: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_step && cclr && cmpa == 10'h000 && cnt == CTM_CNT_MAX)
    |-> !a_set ##1 cnt == 10'h000)
    else $error("overflow with zero A misbehaved");
  chk_pwm_period: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_step && is_pwm && !dpx && rp != 3'h0)
    |-> ({1'b0, cnt} < ctm_scale128(rp)))
    else $error("PWM count passed its period");
  chk_pwm_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_step && is_pwm && p_hit) |=> flag_p)
    else $error("PWM P match flag missing");
  chk_read_answer: assert property (@(posedge clk) disable iff (!rst_n)
    rd_en |=> s_axi_rvalid)
    else $error("read not answered next cycle");

  cov_cmp_toggle: cover property (@(posedge clk) disable iff (!rst_n)
    mode == CTM_MODE_CMP && a_set && io_fn == 2'b11);
  cov_pwm_swap: cover property (@(posedge clk) disable iff (!rst_n)
    is_pwm && dpx && cnt_step && a_hit);
  cov_flag_race: cover property (@(posedge clk) disable iff (!rst_n)
    a_set && clr_a);

endmodule // ctm_timer
`default_nettype wire

// >>> testbench/ctm_load.sv
// load model on the timer output pin: counts driven-high cycles and edges
// assumes the pin level and enable come straight from the timer block
`default_nettype none
module ctm_load (
  input wire logic clk, // system clock
  input wire logic pin, // pin level
  input wire logic pin_en, // pin driven
  output var int high_cnt, // cycles driven high
  output var int edge_cnt // level changes seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last = 1'b0;
  initial high_cnt = 0;
  initial edge_cnt = 0;
  // an undriven pin adds no high cycles and no edges; edges compare driven levels only
  always @(posedge clk) begin
    if (pin_en === 1'b1 && pin === 1'b1) high_cnt <= high_cnt + 1;
    if (pin_en === 1'b1 && pin !== last) edge_cnt <= edge_cnt + 1;
    if (pin_en === 1'b1) last <= pin;
  end
endmodule // ctm_load
`default_nettype wire

// >>> testbench/ctm_timer_test.sv
// self-checking bench for the compact timer over AXI4-Lite
// assumes count_tick held high so the counter steps every clock, until the last check drops it
`default_nettype none
module ctm_timer_test import ctm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, tick = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'h1;
  logic awready, wready, bvalid, arready, rvalid, pin, pin_en;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] clk_sel;
  logic [31:0] d, d1;
  int mismatches = 0, checked = 0, high_cnt, edge_cnt, h0;
  always #5 clk = ~clk;
  ctm_timer ctm_timer_i (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .count_tick(tick),
    .clk_sel(clk_sel), .timer_out(pin), .timer_out_en(pin_en));
  ctm_load ctm_load_i (.clk(clk), .pin(pin), .pin_en(pin_en),
    .high_cnt(high_cnt), .edge_cnt(edge_cnt));
  //////////////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task lost;
    mismatches++;
    $display("unexpected bus hang: no response");
    test_done();
  endtask
  // each task starts just after an edge and ends just after one
  task wr(input logic [7:0] a, input logic [7:0] v);
    int i;
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      // release only once; a second release would collide with the next call
      if (awvalid && awready === 1'b1) awvalid <= 0;
      if (wvalid && wready === 1'b1) wvalid <= 0;
      if (bvalid === 1'b1) break;
    end
    if (i == 50) lost();
    // bready stays high between writes so no edge sees it dropped and raised
    resp = bresp;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    int i;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 0;
      if (rvalid === 1'b1) break;
    end
    if (i == 50) lost();
    v = rdata;
    resp = rresp;
  endtask
  // reprogram with the timer off, then switch it on
  task run(input logic [7:0] c0, c1, input logic [9:0] a);
    wr(CTM_OFF_CTRL0, 8'h00);
    wr(CTM_OFF_CTRL1, c1);
    wr(CTM_OFF_CMPL, a[7:0]);
    wr(CTM_OFF_CMPH, {6'h0, a[9:8]});
    wr(CTM_OFF_FLAG, 8'h03);
    wr(CTM_OFF_CTRL0, c0);
  endtask
  task cmp_case(input logic [7:0] c1, input logic lvl);
    run(8'h08, c1, 10'd5);
    repeat (40) @(posedge clk);
    chk("compare pin", pin, lvl);
    rd(CTM_OFF_FLAG, d);
    chk("clear on A flags", d, 32'h1);
  endtask
  task pwm_case(input logic [7:0] c1, input logic [9:0] a, input int exp);
    run(8'h09, c1, a);
    repeat (30) @(posedge clk);
    h0 = high_cnt;
    repeat (512) @(posedge clk);
    chk("pwm high cycles", high_cnt - h0, exp);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), d);
      chk("reset value", d, 32'h0);
    end
    rd(8'h1c, d);
    chk("unmapped read resp", resp, CTM_RESP_ERR);
    wr(CTM_OFF_CMPH, 8'hff);
    rd(CTM_OFF_CMPH, d);
    chk("compare high bits", d, 32'h3);
    wr(CTM_OFF_CMPL, 8'ha5);
    rd(CTM_OFF_CMPL, d);
    chk("compare low byte", d, 32'ha5);
    wr(CTM_OFF_CNTL, 8'h55);
    chk("read-only write resp", resp, CTM_RESP_OK);
    wr(8'h1c, 8'h01);
    chk("unmapped write resp", resp, CTM_RESP_ERR);
    rd(CTM_OFF_CNTL, d);
    chk("count read-only", d, 32'h0);
    wr(CTM_OFF_CTRL0, 8'h70);
    chk("clock select", clk_sel, 3'h7);
    $display("register test done");
    cmp_case(8'h09, 1'b1);
    cmp_case(8'h19, 1'b0);
    cmp_case(8'h21, 1'b1);
    chk("compare pin enable", pin_en, 1'b1);
    run(8'h08, 8'h31, 10'd5);
    repeat (10) @(posedge clk);
    h0 = edge_cnt;
    repeat (60) @(posedge clk);
    chk("toggle edges", edge_cnt - h0, 32'd12);
    run(8'h08, 8'h00, 10'd5);
    repeat (1100) @(posedge clk);
    rd(CTM_OFF_FLAG, d);
    chk("clear on P flags", d, 32'h3);
    run(8'h08, 8'h21, 10'd0);
    repeat (1100) @(posedge clk);
    rd(CTM_OFF_FLAG, d);
    chk("A zero flags", d, 32'h0);
    run(8'h08, 8'hc0, 10'd5);
    repeat (1100) @(posedge clk);
    rd(CTM_OFF_FLAG, d);
    chk("timer mode flags", d, 32'h3);
    chk("timer mode pin enable", pin_en, 1'b0);
    $display("compare test done");
    pwm_case(8'ha8, 10'd32, 128);
    pwm_case(8'ha9, 10'd32, 128);
    pwm_case(8'ha8, 10'd200, 512);
    pwm_case(8'hac, 10'd32, 384);
    pwm_case(8'haa, 10'd256, 256);
    pwm_case(8'h98, 10'd32, 512);
    pwm_case(8'h88, 10'd32, 0);
    rd(CTM_OFF_FLAG, d);
    chk("pwm forced flags", d, 32'h3);
    wr(CTM_OFF_CTRL1, 8'h40);
    @(posedge clk);
    chk("undefined mode pin enable", pin_en, 1'b0);
    wr(CTM_OFF_CTRL0, 8'h00);
    rd(CTM_OFF_CNTL, d1);
    repeat (20) @(posedge clk);
    rd(CTM_OFF_CNTL, d);
    chk("count held when off", d, d1);
    wr(CTM_OFF_CTRL0, 8'h88);
    repeat (20) @(posedge clk);
    rd(CTM_OFF_CNTL, d);
    chk("count paused after start", d, 32'h0);
    tick <= 0;
    wr(CTM_OFF_CTRL0, 8'h08);
    repeat (20) @(posedge clk);
    rd(CTM_OFF_CNTL, d);
    chk("count without tick", d, 32'h0);
    $display("pwm test done");
    test_done();
  end
endmodule // ctm_timer_test
`default_nettype wire
